// ---- ccr_host.sv ----
`default_nettype none
module ccr_host (
  input wire logic core_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Reserved high bits set only where a refusal is wanted
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge core_clk);
    #1;
    reg_wr = 1'b0;
    // Released bus shows junk so a stale byte cannot pass
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge core_clk);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
  endtask
endmodule
`default_nettype wire

// ---- ccr_pkg.sv ----
// Functional notes
// - Overvoltage sets flag, disables converter
// - Flag latched until zero write or unplug
// - Latch-off and boost faults held until read
// - Throttle status reports seven trigger flags
// - Seven-bit setpoint, 64 mA steps
// - Field at high 4:0, low 7:6
// - Setpoint zero after power-on reset
// - Input-good low, not overvoltage, clears setpoint
// - Battery removal clears setpoint
// - Other faults leave setpoint unchanged
// - Top high-byte bits set make write invalid
// - Low six bits of low byte ignored
// - Linear battery switch mode by default
// - Multi-cell pre-charge current clamped to 384 mA
// - Single cell pre-charge below 3 V, 384 mA
// - Single cell 3 to 3.6 V, 2 A clamp
// - Input-good mirrored in status high byte
`default_nettype none
package ccr_pkg;
  localparam logic [7:0] ADDR_ICHG_LO = 8'h02;
  localparam logic [7:0] ADDR_ICHG_HI = 8'h03;
  localparam logic [7:0] ADDR_STAT_LO = 8'h20;
  localparam logic [7:0] ADDR_STAT_HI = 8'h21;
  localparam logic [7:0] ADDR_THR_LO = 8'h22;
  localparam logic [7:0] ADDR_THR_HI = 8'h23;
  localparam int STAT_OVP_BIT = 4;
  localparam int STAT_LATCH_BIT = 2;
  localparam int STAT_BOVP_BIT = 1;
  localparam int STAT_BOCP_BIT = 0;
  localparam int STAT_GOOD_BIT = 7;
  localparam logic [7:0] HI_RSVD_MASK = 8'hE0;
  localparam logic [7:0] HI_FIELD_MASK = 8'h1F;
  localparam logic [7:0] LO_FIELD_MASK = 8'hC0;
  localparam logic [15:0] ICHG_RESET = 16'h0000;
  localparam logic [15:0] ICHG_FIELD_MASK = 16'h1FC0;
  localparam int ICHG_LSB = 6;
  localparam int STEP_MA = 64;
  // Clamp codes in 64 mA steps: 384 mA and 2 A (rounded down)
  localparam logic [6:0] PRE_CLAMP_CODE = 7'(384 / STEP_MA);
  localparam logic [6:0] MID_CLAMP_CODE = 7'(2000 / STEP_MA);
  localparam logic LINEAR_MODE_DEFAULT = 1'b1;
  function automatic logic [6:0] ccr_min7(input logic [6:0] a,
                                          input logic [6:0] b);
    ccr_min7 = (a < b) ? a : b;
  endfunction
endpackage
`default_nettype wire

// ---- ccr_regs.sv ----
`default_nettype none
module ccr_regs (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic wr_invalid,
  input wire logic input_good_pin,
  input wire logic input_overvoltage_pin,
  input wire logic system_overvoltage_pin,
  input wire logic latchoff_fault_pin,
  input wire logic boost_overvoltage_pin,
  input wire logic boost_overcurrent_pin,
  input wire logic cell_count_battery_present_pin,
  input wire logic [6:0] throttle_trigger_pin,
  input wire logic single_cell,
  input wire logic in_precharge,
  input wire logic batt_above_min_sys,
  input wire logic linear_mode_cfg,
  output logic converter_enable,
  output logic battery_switch_linear,
  output logic [6:0] charge_current_code
);
  logic [12:0] s1, s2;
  logic input_good, ovp_in, input_overvoltage, batpres;
  logic input_good_d, batpres_d;
  logic system_overvoltage_flag, latchoff_fault;
  logic boost_overvoltage_fault, boost_overcurrent_fault;
  logic [6:0] throttle_flags;
  logic [15:0] charge_current_setpoint;
  logic [7:0] stat_lo, next_rdata;
  logic [6:0] field, clamp;
  logic rd_stat, clr_setpoint, hi_bad;

  // Two-stage synchronisers for all pin inputs
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s1 <= 13'h0000;
      s2 <= 13'h0000;
    end else begin
      s1 <= {input_good_pin, input_overvoltage_pin, system_overvoltage_pin,
             cell_count_battery_present_pin, boost_overcurrent_pin,
             boost_overvoltage_pin, latchoff_fault_pin, throttle_trigger_pin[5:0]
             } ^ 13'h0000;
      s2 <= s1;
    end
  end
  logic [6:0] thr_s1, thr_s2;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      thr_s1 <= 7'h00;
      thr_s2 <= 7'h00;
    end else begin
      thr_s1 <= throttle_trigger_pin;
      thr_s2 <= thr_s1;
    end
  end
  assign input_good = s2[12];
  assign input_overvoltage = s2[11];
  assign ovp_in = s2[10];
  assign batpres = s2[9];
  assign throttle_flags = thr_s2;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      input_good_d <= 1'b0;
      batpres_d <= 1'b0;
    end else begin
      input_good_d <= input_good;
      batpres_d <= batpres;
    end
  end

  assign rd_stat = reg_rd && (reg_addr == ccr_pkg::ADDR_STAT_LO);
  assign hi_bad = (reg_wdata & ccr_pkg::HI_RSVD_MASK) != 8'h00;

  // Set wins over clear; unplug also clears
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      system_overvoltage_flag <= 1'b0;
    end else if (ovp_in) begin
      system_overvoltage_flag <= 1'b1;
    end else if ((reg_wr && reg_addr == ccr_pkg::ADDR_STAT_LO &&
                 !reg_wdata[ccr_pkg::STAT_OVP_BIT]) || !input_good) begin
      system_overvoltage_flag <= 1'b0;
    end
  end
  // Lockout stays while flag latched
  assign converter_enable = !system_overvoltage_flag && !ovp_in;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      latchoff_fault <= 1'b0;
      boost_overvoltage_fault <= 1'b0;
      boost_overcurrent_fault <= 1'b0;
    end else begin
      // A fault during the read is kept for the next read
      latchoff_fault <= s2[6] | (latchoff_fault & !rd_stat);
      boost_overvoltage_fault <= s2[7] |
                                 (boost_overvoltage_fault & !rd_stat);
      boost_overcurrent_fault <= s2[8] |
                                 (boost_overcurrent_fault & !rd_stat);
    end
  end

  // Input overvoltage drop of input-good keeps the setpoint
  assign clr_setpoint = (input_good_d && !input_good && !input_overvoltage)
                        || (batpres_d && !batpres);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      charge_current_setpoint <= ccr_pkg::ICHG_RESET;
    end else if (clr_setpoint) begin
      charge_current_setpoint <= ccr_pkg::ICHG_RESET;
    end else if (reg_wr && reg_addr == ccr_pkg::ADDR_ICHG_HI && !hi_bad) begin
      charge_current_setpoint[15:8] <= reg_wdata & ccr_pkg::HI_FIELD_MASK;
    end else if (reg_wr && reg_addr == ccr_pkg::ADDR_ICHG_LO) begin
      charge_current_setpoint[7:0] <= reg_wdata & ccr_pkg::LO_FIELD_MASK;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_invalid <= 1'b0;
    end else begin
      wr_invalid <= reg_wr && reg_addr == ccr_pkg::ADDR_ICHG_HI && hi_bad;
    end
  end

  assign field = charge_current_setpoint[12:6];
  always_comb begin
    clamp = 7'h7F;
    if (in_precharge) begin
      clamp = ccr_pkg::PRE_CLAMP_CODE;
    end else if (single_cell && !batt_above_min_sys) begin
      clamp = ccr_pkg::MID_CLAMP_CODE;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      charge_current_code <= 7'h00;
      battery_switch_linear <= ccr_pkg::LINEAR_MODE_DEFAULT;
    end else begin
      charge_current_code <= ccr_pkg::ccr_min7(field, clamp);
      battery_switch_linear <= linear_mode_cfg &&
        (in_precharge || (single_cell && !batt_above_min_sys));
    end
  end

  always_comb begin
    stat_lo = 8'h00;
    stat_lo[ccr_pkg::STAT_OVP_BIT] = system_overvoltage_flag;
    stat_lo[ccr_pkg::STAT_LATCH_BIT] = latchoff_fault;
    stat_lo[ccr_pkg::STAT_BOVP_BIT] = boost_overvoltage_fault;
    stat_lo[ccr_pkg::STAT_BOCP_BIT] = boost_overcurrent_fault;
    case (reg_addr)
      ccr_pkg::ADDR_ICHG_LO: next_rdata = charge_current_setpoint[7:0];
      ccr_pkg::ADDR_ICHG_HI: next_rdata = charge_current_setpoint[15:8];
      ccr_pkg::ADDR_STAT_LO: next_rdata = stat_lo;
      ccr_pkg::ADDR_STAT_HI: next_rdata = {input_good, 7'h00};
      ccr_pkg::ADDR_THR_LO: next_rdata = {1'b0, throttle_flags};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  a_ovp_lockout: assert property (@(posedge core_clk) disable iff (rst)
    system_overvoltage_flag |-> !converter_enable)
    else $error("converter enabled during overvoltage latch");
  a_ovp_sets: assert property (@(posedge core_clk) disable iff (rst)
    ovp_in |=> system_overvoltage_flag)
    else $error("overvoltage flag not set");
  a_ovp_holds: assert property (@(posedge core_clk) disable iff (rst)
    system_overvoltage_flag && input_good && !reg_wr |=>
    system_overvoltage_flag)
    else $error("overvoltage flag dropped without clear");
  a_fault_clear: assert property (@(posedge core_clk) disable iff (rst)
    rd_stat && !s2[6] |=> !latchoff_fault)
    else $error("latch-off fault not cleared by read");
  a_fault_hold: assert property (@(posedge core_clk) disable iff (rst)
    boost_overvoltage_fault && !rd_stat |=> boost_overvoltage_fault)
    else $error("boost fault dropped without read");
  a_field_shape: assert property (@(posedge core_clk) disable iff (rst)
    (charge_current_setpoint & ~ccr_pkg::ICHG_FIELD_MASK) == 16'h0000)
    else $error("setpoint holds bits outside field");
  a_clr_setpoint: assert property (@(posedge core_clk) disable iff (rst)
    clr_setpoint |=> charge_current_setpoint == 16'h0000)
    else $error("setpoint not cleared");
  a_bad_write: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && reg_addr == ccr_pkg::ADDR_ICHG_HI && hi_bad && !clr_setpoint
    |=> $stable(charge_current_setpoint) && wr_invalid)
    else $error("invalid write changed setpoint");
  a_pre_clamp: assert property (@(posedge core_clk) disable iff (rst)
    in_precharge |=> charge_current_code <= ccr_pkg::PRE_CLAMP_CODE)
    else $error("pre-charge clamp exceeded");

  // Converter lockout follows the raw condition and the latch together
  a_ovp_no_run: assert property (@(posedge core_clk) disable iff (rst)
    ovp_in |-> !converter_enable)
    else $error("converter enabled during overvoltage");

  a_ovp_run_ok: assert property (@(posedge core_clk) disable iff (rst)
    !system_overvoltage_flag && !ovp_in |-> converter_enable)
    else $error("converter held off without cause");

  a_ovp_unplug: assert property (@(posedge core_clk) disable iff (rst)
    !input_good && !ovp_in |=> !system_overvoltage_flag)
    else $error("unplug did not clear overvoltage flag");

  a_ovp_wr_clear: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && reg_addr == ccr_pkg::ADDR_STAT_LO &&
    !reg_wdata[ccr_pkg::STAT_OVP_BIT] && !ovp_in |=>
    !system_overvoltage_flag)
    else $error("zero write did not clear overvoltage flag");

  a_ovp_wr_one: assert property (@(posedge core_clk) disable iff (rst)
    system_overvoltage_flag && input_good && reg_wr &&
    reg_addr == ccr_pkg::ADDR_STAT_LO && reg_wdata[ccr_pkg::STAT_OVP_BIT]
    |=> system_overvoltage_flag)
    else $error("one write cleared overvoltage flag");

  // Fault latches: set from the synchronised pin, held until a read
  a_latch_sets: assert property (@(posedge core_clk) disable iff (rst)
    s2[6] |=> latchoff_fault)
    else $error("latch-off fault not set");

  a_bovp_sets: assert property (@(posedge core_clk) disable iff (rst)
    s2[7] |=> boost_overvoltage_fault)
    else $error("boost overvoltage fault not set");

  a_bocp_sets: assert property (@(posedge core_clk) disable iff (rst)
    s2[8] |=> boost_overcurrent_fault)
    else $error("boost overcurrent fault not set");

  a_latch_hold: assert property (@(posedge core_clk) disable iff (rst)
    latchoff_fault && !rd_stat |=> latchoff_fault)
    else $error("latch-off fault dropped without read");

  a_bocp_hold: assert property (@(posedge core_clk) disable iff (rst)
    boost_overcurrent_fault && !rd_stat |=> boost_overcurrent_fault)
    else $error("boost overcurrent fault dropped without read");

  a_bovp_clear: assert property (@(posedge core_clk) disable iff (rst)
    rd_stat && !s2[7] |=> !boost_overvoltage_fault)
    else $error("boost overvoltage fault not cleared by read");

  a_bocp_clear: assert property (@(posedge core_clk) disable iff (rst)
    rd_stat && !s2[8] |=> !boost_overcurrent_fault)
    else $error("boost overcurrent fault not cleared by read");

  // Read data views
  a_stat_rsvd: assert property (@(posedge core_clk) disable iff (rst)
    rd_stat |=> reg_rdata[7:5] == 3'h0 && !reg_rdata[3])
    else $error("reserved status bits read nonzero");

  a_stat_view: assert property (@(posedge core_clk) disable iff (rst)
    rd_stat |=> reg_rdata[ccr_pkg::STAT_OVP_BIT] ==
    $past(system_overvoltage_flag))
    else $error("overvoltage flag misreported");

  a_thr_view: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == ccr_pkg::ADDR_THR_LO |=>
    reg_rdata == {1'b0, $past(throttle_flags)})
    else $error("throttle flags misreported");

  a_thr_hi_zero: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == ccr_pkg::ADDR_THR_HI |=> reg_rdata == 8'h00)
    else $error("throttle high byte nonzero");

  a_good_view: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == ccr_pkg::ADDR_STAT_HI |=>
    reg_rdata == {$past(input_good), 7'h00})
    else $error("input-good misreported");

  a_rdata_hold: assert property (@(posedge core_clk) disable iff (rst)
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");

  a_ichg_read: assert property (@(posedge core_clk) disable iff (rst)
    reg_rd && reg_addr == ccr_pkg::ADDR_ICHG_HI |=>
    reg_rdata == $past(charge_current_setpoint[15:8]))
    else $error("setpoint high byte misreported");

  // Setpoint clear sources and the events that must leave it alone
  a_batt_clear: assert property (@(posedge core_clk) disable iff (rst)
    batpres_d && !batpres |=> charge_current_setpoint == 16'h0000)
    else $error("battery removal did not clear setpoint");

  a_input_overvoltage_keep: assert property (@(posedge core_clk) disable iff (rst)
    input_good_d && !input_good && input_overvoltage &&
    batpres == batpres_d && !reg_wr |=> $stable(charge_current_setpoint))
    else $error("input overvoltage cleared setpoint");

  a_fault_keep: assert property (@(posedge core_clk) disable iff (rst)
    !clr_setpoint && !reg_wr |=> $stable(charge_current_setpoint))
    else $error("setpoint changed without write or clear");

  a_lo_write: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && reg_addr == ccr_pkg::ADDR_ICHG_LO && !clr_setpoint |=>
    charge_current_setpoint[7:0] ==
    ($past(reg_wdata) & ccr_pkg::LO_FIELD_MASK))
    else $error("low byte write mishandled");

  a_hi_write: assert property (@(posedge core_clk) disable iff (rst)
    reg_wr && reg_addr == ccr_pkg::ADDR_ICHG_HI && !hi_bad && !clr_setpoint
    |=> charge_current_setpoint[15:8] ==
    ($past(reg_wdata) & ccr_pkg::HI_FIELD_MASK))
    else $error("high byte write mishandled");

  a_inv_pulse: assert property (@(posedge core_clk) disable iff (rst)
    !(reg_wr && reg_addr == ccr_pkg::ADDR_ICHG_HI && hi_bad) |=>
    !wr_invalid)
    else $error("spurious invalid write pulse");

  // Clamped code never exceeds the programmed field
  a_code_field: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> charge_current_code <= $past(field))
    else $error("code above setpoint");

  a_mid_clamp: assert property (@(posedge core_clk) disable iff (rst)
    !in_precharge && single_cell && !batt_above_min_sys |=>
    charge_current_code <= ccr_pkg::MID_CLAMP_CODE)
    else $error("single cell clamp exceeded");

  a_free_code: assert property (@(posedge core_clk) disable iff (rst)
    !in_precharge && !(single_cell && !batt_above_min_sys) |=>
    charge_current_code == $past(field))
    else $error("code clamped without cause");

  a_lin_pre: assert property (@(posedge core_clk) disable iff (rst)
    in_precharge && linear_mode_cfg |=> battery_switch_linear)
    else $error("switch not linear in pre-charge");

  a_lin_off: assert property (@(posedge core_clk) disable iff (rst)
    !linear_mode_cfg |=> !battery_switch_linear)
    else $error("switch linear while disabled");

  a_lin_fast: assert property (@(posedge core_clk) disable iff (rst)
    !in_precharge && !single_cell |=> !battery_switch_linear)
    else $error("switch linear in multi-cell fast charge");
endmodule
`default_nettype wire

// ---- charger_status_and_charge_current_regs_tb_top.sv ----
`default_nettype none
module charger_status_and_charge_current_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
  typedef struct packed {logic [7:0] wa, wd, ra, ex;} ccr_row_t;
  logic core_clk, rst, reg_wr, reg_rd, wr_invalid, conv_en, sw_lin;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic good, in_ov, sys_ov, latch, b_ov, b_oc, batt, single, prech, above;
  logic lin_cfg;
  logic [6:0] thr, code;
  int err_total = 0;
  int n_checks = 0;
  ccr_row_t rows [5] = '{'{8'h02, 8'hFF, 8'h02, 8'hC0},
    '{8'h03, 8'h1F, 8'h03, 8'h1F}, '{8'h03, 8'hE5, 8'h03, 8'h1F},
    '{8'h22, 8'hFF, 8'h22, 8'h00}, '{8'h21, 8'hFF, 8'h21, 8'h80}};
  ccr_host host (.core_clk(core_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  ccr_regs dut (.core_clk(core_clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .wr_invalid(wr_invalid), .input_good_pin(good),
    .input_overvoltage_pin(in_ov), .system_overvoltage_pin(sys_ov),
    .latchoff_fault_pin(latch), .boost_overvoltage_pin(b_ov),
    .boost_overcurrent_pin(b_oc), .cell_count_battery_present_pin(batt),
    .throttle_trigger_pin(thr), .single_cell(single), .in_precharge(prech),
    .batt_above_min_sys(above), .linear_mode_cfg(lin_cfg),
    .converter_enable(conv_en), .battery_switch_linear(sw_lin),
    .charge_current_code(code));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    #20000;
    err_total++;
    tally_and_finish;
  end
  initial begin
    {rst, good, batt, above} = 4'hF;
    {in_ov, sys_ov, latch, b_ov, b_oc, single, prech} = 7'h00;
    thr = 7'h00;
    lin_cfg = 1'b1;
    wt(6);
    rst = 1'b0;
    host.rd(8'h02);
    `CHK(reg_rdata, 8'h00)
    host.rd(8'h03);
    `CHK(reg_rdata, 8'h00)
    `CHK(sw_lin, 1'b0)
    $display("reset test done");
    foreach (rows[i]) begin
      host.wr(rows[i].wa, rows[i].wd);
      host.rd(rows[i].ra);
      `CHK(reg_rdata, rows[i].ex)
    end
    host.wr(8'h03, 8'hA0);
    `CHK(wr_invalid, 1'b1)
    wt(2);
    `CHK(code, 7'h7F)
    prech = 1'b1;
    wt(2);
    `CHK(code, 7'd6)
    `CHK(sw_lin, 1'b1)
    lin_cfg = 1'b0;
    wt(2);
    `CHK(sw_lin, 1'b0)
    lin_cfg = 1'b1;
    single = 1'b1;
    wt(2);
    `CHK(code, 7'd6)
    {prech, above} = 2'b00;
    wt(2);
    `CHK(code, 7'd31)
    $display("table and clamp tests done");
    {sys_ov, latch, b_ov, b_oc} = 4'hF;
    thr = 7'h7F;
    wt(5);
    `CHK(conv_en, 1'b0)
    {sys_ov, latch, b_ov, b_oc} = 4'h0;
    wt(5);
    `CHK(conv_en, 1'b0)
    host.rd(8'h20);
    `CHK(reg_rdata, 8'h17)
    host.rd(8'h20);
    `CHK(reg_rdata, 8'h10)
    host.rd(8'h22);
    `CHK(reg_rdata, 8'h7F)
    host.wr(8'h20, 8'h00);
    wt(1);
    `CHK(conv_en, 1'b1)
    host.rd(8'h03);
    `CHK(reg_rdata, 8'h1F)
    $display("status tests done");
    {in_ov, good} = 2'b10;
    wt(5);
    host.rd(8'h03);
    `CHK(reg_rdata, 8'h1F)
    {in_ov, good} = 2'b01;
    wt(5);
    good = 1'b0;
    wt(5);
    host.rd(8'h03);
    `CHK(reg_rdata, 8'h00)
    good = 1'b1;
    host.wr(8'h03, 8'h10);
    host.rd(8'h03);
    `CHK(reg_rdata, 8'h10)
    batt = 1'b0;
    wt(5);
    host.rd(8'h03);
    `CHK(reg_rdata, 8'h00)
    $display("setpoint clear tests done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
